// ---- src/amplitude_scaler.sv ----
// Duty cycle sum with offset, and scaling of the table phase currents
`timescale 1ns/1ps
module amplitude_scaler (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] calc_duty,
	input wire logic [8:0] auto_offset,
	input wire logic [8:0] phase_a_current,
	input wire logic [8:0] phase_b_current,
	output logic [7:0] duty_sum,
	output logic [8:0] scaled_phase_a,
	output logic [8:0] scaled_phase_b
);
	wire signed [10:0] raw_sum = $signed({3'b000, calc_duty}) + $signed({{2{auto_offset[8]}}, auto_offset});
	wire [7:0] next_duty = raw_sum[10] ? 8'h00 :
		(raw_sum > $signed({3'b000, drv_regs_pkg::DUTY_MAX})) ? drv_regs_pkg::DUTY_MAX : raw_sum[7:0];
	wire signed [17:0] prod_a = $signed(phase_a_current) * $signed({1'b0, duty_sum});
	wire signed [17:0] prod_b = $signed(phase_b_current) * $signed({1'b0, duty_sum});

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			duty_sum <= 8'h00;
			scaled_phase_a <= 9'h000;
			scaled_phase_b <= 9'h000;
		end else begin
			duty_sum <= next_duty;
			scaled_phase_a <= prod_a[16:8];
			scaled_phase_b <= prod_b[16:8];
		end
	end
endmodule : amplitude_scaler

// ---- src/drv_regs_pkg.sv ----
// Register map, field layout and timing constants of the driver register set
package drv_regs_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 32;

	// Documented offsets
	localparam logic [6:0] OFS_CHOPPER_CONFIG = 7'h6C;
	localparam logic [6:0] OFS_CURRENT_ADAPT_CONFIG = 7'h6D;
	localparam logic [6:0] OFS_DC_COMMUTATION_CTRL = 7'h6E;
	localparam logic [6:0] OFS_DRIVER_STATE_FLAGS = 7'h6F;
	localparam logic [6:0] OFS_VOLTAGE_PWM_CONFIG = 7'h70;
	localparam logic [6:0] OFS_AMPLITUDE_RESULT = 7'h71;
	localparam logic [6:0] OFS_AUTO_PWM_DEFAULTS = 7'h72;
	// Interrupt and option registers
	localparam logic [6:0] OFS_IRQ_STATUS = 7'h7C;
	localparam logic [6:0] OFS_IRQ_MASK = 7'h7D;
	localparam logic [6:0] OFS_DC_OPTION = 7'h7E;

	// Reset values
	localparam logic [31:0] RST_CHOPPER_CONFIG = 32'h10410150;
	localparam logic [24:0] RST_CURRENT_ADAPT_CONFIG = 25'h0000000;
	localparam logic [23:0] RST_DC_COMMUTATION_CTRL = 24'h000000;
	localparam logic [31:0] RST_VOLTAGE_PWM_CONFIG = 32'hC40C001E;
	localparam logic [1:0] RST_IRQ = 2'h0;
	localparam logic [1:0] RST_DC_OPTION = 2'h0;

	// Register widths
	localparam int CURRENT_ADAPT_W = 25;
	localparam int DC_CTRL_W = 24;
	localparam int PWM_CONFIG_W = 32;

	// dc_commutation_ctrl fields
	localparam int COMMUTATION_ON_LIMIT_LSB = 0;
	localparam int COMMUTATION_ON_LIMIT_W = 10;
	localparam int STEP_LOSS_ON_LIMIT_LSB = 16;
	localparam int STEP_LOSS_ON_LIMIT_W = 8;

	// driver_state_flags fields
	localparam int LOAD_VALUE_W = 10;
	localparam int ERROR_FLAGS_W = 22;

	// amplitude_result fields
	localparam int DUTY_SUM_LSB = 0;
	localparam int DUTY_W = 8;
	localparam int AUTO_OFFSET_LSB = 16;
	localparam int AUTO_OFFSET_W = 9;
	localparam logic [7:0] DUTY_MAX = 8'hFF;

	// auto_pwm_defaults fields
	localparam int AUTO_OFS_LSB = 0;
	localparam int AUTO_GRAD_LSB = 16;

	// Phase current width (signed)
	localparam int CURRENT_W = 9;

	// Interrupt status bits
	localparam int IRQ_COMMUTATION = 0;
	localparam int IRQ_STEP_LOSS = 1;
	localparam int IRQ_W = 2;

	// Option bits
	localparam int OPT_HV_FULLSTEP = 0;
	localparam int OPT_HV_CHOPPER = 1;
	localparam int OPT_W = 2;

	// One step-loss unit is 16 device clock cycles
	localparam int STEP_LOSS_UNIT_CYCLES = 16;
	localparam int UNIT_CNT_W = 4;
	localparam logic [3:0] UNIT_LAST = 4'(STEP_LOSS_UNIT_CYCLES - 1);

	typedef enum logic [1:0] {
		MON_IDLE = 2'b00,
		MON_ON = 2'b01,
		MON_DONE = 2'b10
	} monitor_state_type;
endpackage : drv_regs_pkg

// ---- src/on_time_monitor.sv ----
// PWM on-time watch for commutation limit and step-loss detection
`timescale 1ns/1ps
module on_time_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic pwm_on,
	input wire logic [9:0] commutation_on_limit,
	input wire logic [7:0] step_loss_on_limit,
	input wire logic step_loss_allowed,
	output logic commutation_hit,
	output logic step_loss_hit
);
	drv_regs_pkg::monitor_state_type state;
	drv_regs_pkg::monitor_state_type next_state;
	logic [9:0] on_count;
	logic [3:0] unit_div;
	logic [7:0] unit_count;
	logic sg_done;
	wire unit_tick = (unit_div == drv_regs_pkg::UNIT_LAST);
	wire running = (state == drv_regs_pkg::MON_ON) && pwm_on;
	// Step-loss limit sits past the commutation limit, so its watch outlives it
	wire counting = (state != drv_regs_pkg::MON_IDLE) && pwm_on && enable;
	wire limit_reached = running && (on_count == commutation_on_limit);
	wire units_reached = counting && unit_tick && (unit_count + 8'h01 == step_loss_on_limit);
	wire sg_fire = units_reached && step_loss_allowed && (step_loss_on_limit != 8'h00) && !sg_done;

	always_comb begin
		next_state = state;
		unique case (state)
			drv_regs_pkg::MON_IDLE: if (enable && pwm_on) next_state = drv_regs_pkg::MON_ON;
			drv_regs_pkg::MON_ON: begin
				if (!pwm_on || !enable) next_state = drv_regs_pkg::MON_IDLE;
				else if (limit_reached) next_state = drv_regs_pkg::MON_DONE;
			end
			drv_regs_pkg::MON_DONE: if (!pwm_on || !enable) next_state = drv_regs_pkg::MON_IDLE;
			default: next_state = drv_regs_pkg::MON_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= drv_regs_pkg::MON_IDLE;
			on_count <= 10'h000;
			unit_div <= 4'h0;
			unit_count <= 8'h00;
			sg_done <= 1'b0;
			commutation_hit <= 1'b0;
			step_loss_hit <= 1'b0;
		end else begin
			state <= next_state;
			on_count <= running ? on_count + 10'h001 : 10'h001;
			unit_div <= counting ? unit_div + 4'h1 : 4'h0;
			if (!counting) unit_count <= 8'h00;
			else if (unit_tick) unit_count <= unit_count + 8'h01;
			sg_done <= counting && (sg_done || sg_fire);
			commutation_hit <= limit_reached;
			step_loss_hit <= sg_fire;
		end
	end
endmodule : on_time_monitor

// ---- src/stepper_driver_config_regs.sv ----
// Driver register bank: configuration, DC commutation watch, status and amplitude results
`timescale 1ns/1ps
module stepper_driver_config_regs (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [6:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic dc_mode_enable_pin,
	input wire logic above_dc_min_velocity,
	input wire logic above_high_velocity,
	input wire logic pwm_on,
	input wire logic [9:0] load_value,
	input wire logic [21:0] driver_error_flags,
	input wire logic [7:0] calc_duty,
	input wire logic [8:0] auto_offset,
	input wire logic [7:0] auto_ofs_value,
	input wire logic [7:0] auto_gradient_value,
	input wire logic [8:0] phase_a_current,
	input wire logic [8:0] phase_b_current,
	output logic [31:0] chopper_config,
	output logic [24:0] current_adapt_config,
	output logic [31:0] voltage_pwm_config,
	output logic high_velocity_chopper,
	output logic dc_mode_active,
	output logic commutation_end,
	output logic step_loss_event,
	output logic [8:0] scaled_phase_a,
	output logic [8:0] scaled_phase_b,
	output logic irq
);
	logic [23:0] dc_commutation_ctrl;
	logic [1:0] dc_option;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [7:0] duty_sum;
	logic [8:0] auto_offset_q;
	logic [7:0] auto_ofs_q;
	logic [7:0] auto_grad_q;
	logic commutation_hit;
	logic step_loss_hit;

	// Address decode
	wire sel_chopper = (reg_addr == drv_regs_pkg::OFS_CHOPPER_CONFIG);
	wire sel_adapt = (reg_addr == drv_regs_pkg::OFS_CURRENT_ADAPT_CONFIG);
	wire sel_dc_ctrl = (reg_addr == drv_regs_pkg::OFS_DC_COMMUTATION_CTRL);
	wire sel_state = (reg_addr == drv_regs_pkg::OFS_DRIVER_STATE_FLAGS);
	wire sel_pwm_cfg = (reg_addr == drv_regs_pkg::OFS_VOLTAGE_PWM_CONFIG);
	wire sel_amp = (reg_addr == drv_regs_pkg::OFS_AMPLITUDE_RESULT);
	wire sel_auto = (reg_addr == drv_regs_pkg::OFS_AUTO_PWM_DEFAULTS);
	wire sel_irq_status = (reg_addr == drv_regs_pkg::OFS_IRQ_STATUS);
	wire sel_irq_mask = (reg_addr == drv_regs_pkg::OFS_IRQ_MASK);
	wire sel_option = (reg_addr == drv_regs_pkg::OFS_DC_OPTION);

	// only writable registers decode a write
	wire wr_chopper = reg_write && sel_chopper;
	wire wr_adapt = reg_write && sel_adapt;
	wire wr_dc_ctrl = reg_write && sel_dc_ctrl;
	wire wr_pwm_cfg = reg_write && sel_pwm_cfg;
	wire wr_irq_status = reg_write && sel_irq_status;
	wire wr_irq_mask = reg_write && sel_irq_mask;
	wire wr_option = reg_write && sel_option;

	// Field extraction
	wire [9:0] commutation_on_limit = dc_commutation_ctrl[drv_regs_pkg::COMMUTATION_ON_LIMIT_LSB
		+: drv_regs_pkg::COMMUTATION_ON_LIMIT_W];
	wire [7:0] step_loss_on_limit = dc_commutation_ctrl[drv_regs_pkg::STEP_LOSS_ON_LIMIT_LSB
		+: drv_regs_pkg::STEP_LOSS_ON_LIMIT_W];

	// pin or velocity enables DC mode
	wire next_dc_mode = dc_mode_enable_pin || above_dc_min_velocity;

	wire step_loss_allowed = !above_high_velocity || dc_option[drv_regs_pkg::OPT_HV_FULLSTEP];

	// Event vector; set beats a same-cycle clear
	wire [1:0] events = {step_loss_hit, commutation_hit};
	wire [1:0] next_irq_status = events
		| (irq_status & ~(wr_irq_status ? reg_wdata[drv_regs_pkg::IRQ_W-1:0] : 2'h0));
	wire next_irq = |(next_irq_status & irq_mask);

	// load value low, error flags high
	wire [31:0] state_word = {driver_error_flags, load_value};

	wire [31:0] amp_word = {7'h00, auto_offset_q, 8'h00, duty_sum};

	wire [31:0] auto_word = {8'h00, auto_grad_q, 8'h00, auto_ofs_q};

	// write-only registers read as zero, left untouched
	wire [31:0] next_rdata =
		sel_chopper ? chopper_config :
		sel_state ? state_word :
		sel_amp ? amp_word :
		sel_auto ? auto_word :
		sel_irq_status ? {30'h00000000, irq_status} :
		sel_irq_mask ? {30'h00000000, irq_mask} :
		sel_option ? {30'h00000000, dc_option} :
		32'h00000000;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) chopper_config <= drv_regs_pkg::RST_CHOPPER_CONFIG;
		else if (wr_chopper) chopper_config <= reg_wdata;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) current_adapt_config <= drv_regs_pkg::RST_CURRENT_ADAPT_CONFIG;
		else if (wr_adapt) current_adapt_config <= reg_wdata[drv_regs_pkg::CURRENT_ADAPT_W-1:0];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) dc_commutation_ctrl <= drv_regs_pkg::RST_DC_COMMUTATION_CTRL;
		else if (wr_dc_ctrl) dc_commutation_ctrl <= reg_wdata[drv_regs_pkg::DC_CTRL_W-1:0];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) voltage_pwm_config <= drv_regs_pkg::RST_VOLTAGE_PWM_CONFIG;
		else if (wr_pwm_cfg) voltage_pwm_config <= reg_wdata[drv_regs_pkg::PWM_CONFIG_W-1:0];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dc_option <= drv_regs_pkg::RST_DC_OPTION;
			high_velocity_chopper <= 1'b0;
		end else begin
			if (wr_option) dc_option <= reg_wdata[drv_regs_pkg::OPT_W-1:0];
			high_velocity_chopper <= dc_option[drv_regs_pkg::OPT_HV_CHOPPER];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_status <= drv_regs_pkg::RST_IRQ;
			irq_mask <= drv_regs_pkg::RST_IRQ;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (wr_irq_mask) irq_mask <= reg_wdata[drv_regs_pkg::IRQ_W-1:0];
			irq <= next_irq;
		end
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) reg_rdata <= 32'h00000000;
		else if (reg_read) reg_rdata <= next_rdata;
		else reg_rdata <= 32'h00000000;
	end

	// Registered inputs so amplitude and default reads are a clean snapshot
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			auto_offset_q <= 9'h000;
			auto_ofs_q <= 8'h00;
			auto_grad_q <= 8'h00;
			dc_mode_active <= 1'b0;
			commutation_end <= 1'b0;
			step_loss_event <= 1'b0;
		end else begin
			auto_offset_q <= auto_offset;
			auto_ofs_q <= auto_ofs_value;
			auto_grad_q <= auto_gradient_value;
			dc_mode_active <= next_dc_mode;
			commutation_end <= commutation_hit;
			step_loss_event <= step_loss_hit;
		end
	end

	on_time_monitor monitor (
		.clk(clk),
		.resetn(resetn),
		.enable(dc_mode_active),
		.pwm_on(pwm_on),
		.commutation_on_limit(commutation_on_limit),
		.step_loss_on_limit(step_loss_on_limit),
		.step_loss_allowed(step_loss_allowed),
		.commutation_hit(commutation_hit),
		.step_loss_hit(step_loss_hit)
	);

	amplitude_scaler scaler (
		.clk(clk),
		.resetn(resetn),
		.calc_duty(calc_duty),
		.auto_offset(auto_offset),
		.phase_a_current(phase_a_current),
		.phase_b_current(phase_b_current),
		.duty_sum(duty_sum),
		.scaled_phase_a(scaled_phase_a),
		.scaled_phase_b(scaled_phase_b)
	);
endmodule : stepper_driver_config_regs

// ---- testbench/drv_regs_chk.sv ----
// Port-level assertions for the driver register bank
`timescale 1ns/1ps
module drv_regs_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [6:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic dc_mode_enable_pin,
	input wire logic above_dc_min_velocity,
	input wire logic [9:0] load_value,
	input wire logic [21:0] driver_error_flags,
	input wire logic [7:0] auto_ofs_value,
	input wire logic [7:0] auto_gradient_value,
	input wire logic [31:0] chopper_config,
	input wire logic [24:0] current_adapt_config,
	input wire logic dc_mode_active,
	input wire logic commutation_end
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_rd_idle;
		!$past(reg_read) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_chop_wr;
		reg_write && reg_addr == 7'h6C |=> chopper_config == $past(reg_wdata);
	endproperty
	a_chop_wr: assert property (p_chop_wr) else $error("chopper write lost");
	property p_adapt_wr;
		reg_write && reg_addr == 7'h6D |=> current_adapt_config == $past(reg_wdata[24:0]);
	endproperty
	a_adapt_wr: assert property (p_adapt_wr) else $error("adapt write lost");
	property p_wo_rd;
		reg_read && (reg_addr == 7'h6D || reg_addr == 7'h6E || reg_addr == 7'h70)
			|=> reg_rdata == 32'h0;
	endproperty
	a_wo_rd: assert property (p_wo_rd) else $error("write-only read not zero");
	property p_flags_rd;
		reg_read && reg_addr == 7'h6F && $stable(load_value) && $stable(driver_error_flags)
			|=> reg_rdata == {$past(driver_error_flags), $past(load_value)};
	endproperty
	a_flags_rd: assert property (p_flags_rd) else $error("status read wrong");
	property p_defaults_rd;
		reg_read && reg_addr == 7'h72 && $stable(auto_ofs_value) && $stable(auto_gradient_value)
			|=> reg_rdata == {8'h00, $past(auto_gradient_value), 8'h00, $past(auto_ofs_value)};
	endproperty
	a_defaults_rd: assert property (p_defaults_rd) else $error("defaults read wrong");
	property p_dc_mode;
		1'b1 |=> dc_mode_active == $past(dc_mode_enable_pin || above_dc_min_velocity);
	endproperty
	a_dc_mode: assert property (p_dc_mode) else $error("dc mode wrong");
	property p_end_pulse;
		commutation_end |=> !commutation_end;
	endproperty
	a_end_pulse: assert property (p_end_pulse) else $error("commutation pulse too long");
endmodule : drv_regs_chk

bind stepper_driver_config_regs drv_regs_chk chk (.clk, .resetn, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .dc_mode_enable_pin, .above_dc_min_velocity,
	.load_value, .driver_error_flags, .auto_ofs_value, .auto_gradient_value,
	.chopper_config, .current_adapt_config, .dc_mode_active, .commutation_end);

// ---- testbench/test_stepper_driver_config_regs.sv ----
// Self-checking bench for the driver register bank
`timescale 1ns/1ps
module test_stepper_driver_config_regs;
	logic clk, resetn, reg_write, reg_read, dc_mode_enable_pin, above_dc_min_velocity;
	logic above_high_velocity, pwm_on, high_velocity_chopper, dc_mode_active;
	logic commutation_end, step_loss_event, irq;
	logic [6:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, chopper_config, voltage_pwm_config;
	logic [9:0] load_value;
	logic [21:0] driver_error_flags;
	logic [7:0] calc_duty, auto_ofs_value, auto_gradient_value;
	logic [8:0] auto_offset, phase_a_current, phase_b_current, scaled_phase_a, scaled_phase_b;
	logic [24:0] current_adapt_config;
	int error_cnt = 0;
	int checks = 0;
	int n;
	stepper_driver_config_regs uut (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_range(input int got, input int lo, input int hi);
		checks++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : cmp_range
	task automatic wr(input logic [6:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 cmp(reg_rdata, exp);
	endtask : rd
	// One on phase; count cycles until the chosen pulse, giving up at lim
	task automatic on_phase(input bit sl, input int lim, output int cnt);
		@(posedge clk);
		pwm_on <= 1'b1;
		cnt = 0;
		do begin
			@(posedge clk);
			#1 cnt++;
		end while (cnt < lim && (sl ? step_loss_event : commutation_end) !== 1'b1);
		pwm_on <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : on_phase
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	initial begin
		resetn = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		dc_mode_enable_pin = 1'b0;
		above_dc_min_velocity = 1'b0;
		above_high_velocity = 1'b0;
		pwm_on = 1'b0;
		load_value = 10'h2B7;
		driver_error_flags = 22'h15A5A5;
		calc_duty = 8'h80;
		auto_offset = 9'h010;
		auto_ofs_value = 8'h5A;
		auto_gradient_value = 8'hC3;
		phase_a_current = 9'h064;
		phase_b_current = 9'h0C8;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		#1 cmp(chopper_config, 32'h10410150);
		cmp(voltage_pwm_config, 32'hC40C001E);
		rd(7'h6C, 32'h10410150);
		wr(7'h6C, 32'hA5C30F96);
		rd(7'h6C, 32'hA5C30F96);
		wr(7'h6D, 32'hFFFFFFFF);
		#1 cmp({7'h00, current_adapt_config}, 32'h01FFFFFF);
		rd(7'h6D, 32'h0);
		cmp({7'h00, current_adapt_config}, 32'h01FFFFFF);
		wr(7'h70, 32'h00123456);
		#1 cmp(voltage_pwm_config, 32'h00123456);
		rd(7'h70, 32'h0);
		// Writes to read-only places and an unmapped one must be dropped
		for (int i = 0; i < 4; i++) wr(i == 3 ? 7'h10 : 7'h6F + 7'(i == 0 ? 0 : i + 1), 32'hFFFFFFFF);
		rd(7'h6F, {driver_error_flags, load_value});
		rd(7'h71, 32'h00100090);
		rd(7'h72, 32'h00C3005A);
		rd(7'h10, 32'h0);
		cmp({14'h0, scaled_phase_b, scaled_phase_a}, {14'h0, 9'h070, 9'h038});
		@(posedge clk);
		calc_duty <= 8'hF0;
		auto_offset <= 9'h020;
		repeat (4) @(posedge clk);
		rd(7'h71, 32'h002000FF);
		cmp({23'h0, scaled_phase_a}, 32'h063);
		calc_duty <= 8'h10;
		auto_offset <= 9'h1E0;
		repeat (4) @(posedge clk);
		rd(7'h71, 32'h01E00000);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			dc_mode_enable_pin <= (i == 1 || i == 3);
			above_dc_min_velocity <= (i >= 2);
			repeat (2) @(posedge clk);
			#1 cmp({31'h0, dc_mode_active}, 32'(i != 0));
		end
		above_dc_min_velocity <= 1'b0;
		wr(7'h6E, 32'h00000005);
		wr(7'h7D, 32'h3);
		on_phase(1'b0, 40, n);
		cmp_range(n, 5, 7);
		cmp({31'h0, irq}, 32'h1);
		rd(7'h7C, 32'h1);
		wr(7'h7C, 32'h1);
		repeat (2) @(posedge clk);
		#1 cmp({31'h0, irq}, 32'h0);
		rd(7'h6E, 32'h0);
		wr(7'h6E, 32'h00000000);
		on_phase(1'b1, 100, n);
		cmp_range(n, 100, 100);
		wr(7'h6E, 32'h00020014);
		on_phase(1'b1, 60, n);
		cmp_range(n, 31, 35);
		above_high_velocity <= 1'b1;
		on_phase(1'b1, 60, n);
		cmp_range(n, 60, 60);
		wr(7'h7E, 32'h3);
		on_phase(1'b1, 60, n);
		cmp_range(n, 31, 35);
		cmp({31'h0, high_velocity_chopper}, 32'h1);
		rd(7'h7C, 32'h3);
		wr(7'h7D, 32'h0);
		repeat (2) @(posedge clk);
		#1 cmp({31'h0, irq}, 32'h0);
		wr(7'h7C, 32'h3);
		rd(7'h7C, 32'h0);
		give_verdict();
	end
endmodule : test_stepper_driver_config_regs
